/* src/slmc_top.sv */
// Purpose: Monitor channel command interpreter with control registers and signalling interrupt
// Assumes: Framer gives one downstream byte per frame on gci_clk; ref_clk far faster than frames
// Notes: Registers live on ref_clk; bytes cross by toggle handshakes held stable for a frame
//
// Overview of operation
// RULE_01: Threshold field zero gives 0 V, otherwise 8 V plus 1 V per count.
// RULE_02: Controller writes zero into the two reserved test bits of the config register.
// RULE_03: Config bit 1 set bypasses the receive high-pass filter.
// RULE_04: Six upper mask bits each block one status source from the interrupt.
// RULE_05: Masked bits never touch the interrupt; unmasked changes set it.
// RULE_06: An unmasked toggle copies status into the shadow and sets the interrupt.
// RULE_07: Once set, later events leave interrupt and shadow alone until readout.
// RULE_08: Status readout gives shadow for unmasked bits, live status for masked bits.
// RULE_09: After readout clear; on difference recapture, hold low two frames, then set.
// RULE_10: With no difference at readout the interrupt stays clear until the next event.
// RULE_11: Reset loads the shadow with the current status.
// RULE_12: A write changing any mask bit recaptures the shadow and clears the interrupt; the code reacts only to changes in mask bits 7 to 2.
// RULE_13: Mask bits 1 and 0 pick linear or PCM coding for receive and transmit.
// RULE_14: The mask register resets to all ones.
// RULE_15: Register write: address, command with bit 6 clear, then 0, 2 or 12 bytes.
// RULE_16: Register read replies address, echo of prior command, then registers in order.
// RULE_17: Echo byte carries line select bits of the previous register command.
// RULE_18: Coefficient write: address, command x0000011, then eight bytes in order.
// RULE_19: While one direction carries bytes, the other carries the idle pattern.
module slmc_top
  import slmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic gci_clk,
  input wire logic frame_sync,
  input wire logic mon_dn_valid,
  input wire logic [7:0] mon_dn_data,
  output logic mon_up_valid,
  output logic [7:0] mon_up_data,
  output logic ci_up_int,
  input wire logic [7:0] status_in,
  output slmc_cfg_t cfg,
  output logic [SLMC_NCOEF*8-1:0] coef_bank
);

  // Link domain
  logic lrst_meta;
  logic lrst_n;
  logic [7:0] dn_hold;
  logic dn_tgl;
  logic frame_tgl;
  logic up_req_l;
  logic up_req_seen;
  logic up_pending;
  logic up_ack_tgl;

  // Reference domain
  logic dn_tgl_r;
  logic dn_tgl_q;
  logic frame_tgl_r;
  logic frame_tgl_q;
  logic up_ack_r;
  logic up_ack_q;
  logic byte_rx;
  logic frame_tick;
  logic ack_seen;
  logic [7:0] status;
  logic [5:0] shadow;
  logic int_flag;
  logic [SLMC_NREG-1:0][7:0] cr;
  logic [SLMC_NCOEF-1:0][7:0] coef;
  slmc_state_t state;
  logic [3:0] cnt;
  logic [3:0] len;
  logic is_top;
  logic [1:0] prev_lsel;
  logic [1:0] echo_lsel;
  logic busy;
  logic up_req_tgl;
  logic [7:0] up_data;
  logic mask_chg;
  logic readout;
  logic [7:0] sr_view;

  // Link reset follows the reference reset through two flops
  always_ff @(posedge gci_clk) begin
    lrst_meta <= rst_n;
    lrst_n <= lrst_meta;
  end

  // Downstream byte held for the whole frame, announced by a toggle
  always_ff @(posedge gci_clk) begin
    if (!lrst_n) begin
      dn_hold <= SLMC_IDLE_BYTE;
      dn_tgl <= 1'b0;
    end else if (mon_dn_valid) begin
      dn_hold <= mon_dn_data;
      dn_tgl <= ~dn_tgl;
    end
  end

  // Frame boundaries cross as a toggle
  always_ff @(posedge gci_clk) begin
    if (!lrst_n) begin
      frame_tgl <= 1'b0;
    end else if (frame_sync) begin
      frame_tgl <= ~frame_tgl;
    end
  end

  slmc_sync #(.W(1), .FILTER(1'b0)) u_sync_up_req (
    .clk(gci_clk),
    .d(up_req_tgl),
    .q(up_req_l)
  );

  slmc_sync #(.W(1), .FILTER(1'b0)) u_sync_int (
    .clk(gci_clk),
    .d(int_flag),
    .q(ci_up_int)
  );

  // Upstream slot: one byte per frame, idle pattern when nothing waits
  always_ff @(posedge gci_clk) begin
    if (!lrst_n) begin
      up_req_seen <= 1'b0;
      up_pending <= 1'b0;
      up_ack_tgl <= 1'b0;
      mon_up_valid <= 1'b0;
      mon_up_data <= SLMC_IDLE_BYTE;
    end else begin
      mon_up_valid <= 1'b0;
      if (up_req_l != up_req_seen) begin
        up_req_seen <= up_req_l;
        up_pending <= 1'b1;
      end
      if (frame_sync) begin
        if (up_pending) begin
          // up_data is quiet here: it only moves after the ack below
          mon_up_data <= up_data;
          mon_up_valid <= 1'b1;
          up_ack_tgl <= ~up_ack_tgl;
          up_pending <= 1'b0;
        end else begin
          mon_up_data <= SLMC_IDLE_BYTE; // [RULE_19]
        end
      end
    end
  end

  slmc_sync #(.W(3), .FILTER(1'b0)) u_sync_tgl (
    .clk(ref_clk),
    .d({dn_tgl, frame_tgl, up_ack_tgl}),
    .q({dn_tgl_r, frame_tgl_r, up_ack_r})
  );

  slmc_sync #(.W(8), .FILTER(1'b1)) u_sync_status (
    .clk(ref_clk),
    .d(status_in),
    .q(status)
  );

  // Edge detect on the synchronised toggles
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dn_tgl_q <= 1'b0;
      frame_tgl_q <= 1'b0;
      up_ack_q <= 1'b0;
    end else begin
      dn_tgl_q <= dn_tgl_r;
      frame_tgl_q <= frame_tgl_r;
      up_ack_q <= up_ack_r;
    end
  end

  assign byte_rx = dn_tgl_r ^ dn_tgl_q;
  assign frame_tick = frame_tgl_r ^ frame_tgl_q;
  assign ack_seen = up_ack_r ^ up_ack_q;

  slmc_event #(.REARM_FRAMES(SLMC_REARM_FRAMES)) u_event (
    .clk(ref_clk),
    .rst_n(rst_n),
    .status(status[7:SLMC_SRC_LSB]),
    .mask(cr[SLMC_IDX_MASK][7:SLMC_SRC_LSB]),
    .mask_chg(mask_chg),
    .readout(readout),
    .frame_tick(frame_tick),
    .shadow(shadow),
    .int_flag(int_flag)
  );

  // Status as read out: shadow where unmasked, live where masked
  assign sr_view = {(shadow & ~cr[SLMC_IDX_MASK][7:SLMC_SRC_LSB]) |
                    (status[7:SLMC_SRC_LSB] & cr[SLMC_IDX_MASK][7:SLMC_SRC_LSB]),
                    status[SLMC_SRC_LSB-1:0]}; // [RULE_08]

  // Command sequencer; downstream bytes during a reply are idle and ignored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_ADDR;
      cnt <= 4'd0;
      len <= 4'd0;
      is_top <= 1'b0;
      prev_lsel <= 2'b00;
      echo_lsel <= 2'b00;
    end else begin
      unique case (state)
        ST_ADDR: begin
          if (byte_rx && dn_hold == SLMC_ADDR_BYTE) begin
            state <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (byte_rx) begin
            cnt <= 4'd0;
            echo_lsel <= prev_lsel;
            state <= ST_ADDR;
            if (!dn_hold[SLMC_CMD_RD_BIT] && dn_hold[6:0] == SLMC_COP_WR) begin
              state <= ST_COEF; // [RULE_18]
            end else if (dn_hold[3:0] == SLMC_TOP_SR && dn_hold[SLMC_CMD_RD_BIT]) begin
              is_top <= 1'b1;
              len <= SLMC_LEN_2;
              state <= ST_RESP;
            end else if (dn_hold[3:0] == SLMC_SOP_0 || dn_hold[3:0] == SLMC_SOP_2 ||
                         dn_hold[3:0] == SLMC_SOP_12) begin
              prev_lsel <= dn_hold[SLMC_LSEL_MSB:SLMC_LSEL_LSB];
              len <= (dn_hold[3:0] == SLMC_SOP_2) ? SLMC_LEN_2 :
                     (dn_hold[3:0] == SLMC_SOP_12) ? SLMC_LEN_12 : 4'd0;
              if (dn_hold[SLMC_CMD_RD_BIT]) begin
                is_top <= 1'b0;
                len <= (dn_hold[3:0] == SLMC_SOP_2) ? 4'(SLMC_LEN_2 + 4'd2) :
                       (dn_hold[3:0] == SLMC_SOP_12) ? 4'(SLMC_LEN_12 + 4'd2) : SLMC_LEN_2;
                state <= ST_RESP; // [RULE_16]
              end else if (dn_hold[3:0] != SLMC_SOP_0) begin
                state <= ST_WDATA; // [RULE_15]
              end
            end
          end
        end
        ST_WDATA: begin
          if (byte_rx) begin
            cnt <= 4'(cnt + 4'd1);
            if (cnt == 4'(len - 4'd1)) begin
              state <= ST_ADDR;
            end
          end
        end
        ST_COEF: begin
          if (byte_rx) begin
            cnt <= 4'(cnt + 4'd1);
            if (cnt == 4'(SLMC_NCOEF - 1)) begin
              state <= ST_ADDR;
            end
          end
        end
        ST_RESP: begin
          if (busy && ack_seen) begin
            cnt <= 4'(cnt + 4'd1);
            if (cnt == 4'(len - 4'd1)) begin
              state <= ST_ADDR;
            end
          end
        end
      endcase
    end
  end

  // Reply bytes go out one at a time, the next only after the link has sent the last
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      up_req_tgl <= 1'b0;
      up_data <= SLMC_IDLE_BYTE;
      readout <= 1'b0;
    end else begin
      readout <= 1'b0;
      if (state == ST_RESP && !busy) begin
        busy <= 1'b1;
        up_req_tgl <= ~up_req_tgl;
        if (cnt == 4'd0) begin
          up_data <= SLMC_ADDR_BYTE;
        end else if (cnt == 4'd1) begin
          up_data <= is_top ? sr_view : {SLMC_ECHO_HI, SLMC_ECHO_MID, echo_lsel}; // [RULE_08] [RULE_17]
        end else begin
          up_data <= cr[4'(cnt - 4'd2)]; // [RULE_16]
        end
      end else if (busy && ack_seen) begin
        busy <= 1'b0;
        // Status readout ends once its byte has left on the link
        readout <= is_top && cnt == 4'(len - 4'd1); // [RULE_09]
      end
    end
  end

  // Control register and coefficient writes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cr <= SLMC_CR_RST; // [RULE_14]
      coef <= '0;
      mask_chg <= 1'b0;
    end else begin
      mask_chg <= 1'b0;
      if (state == ST_WDATA && byte_rx) begin
        cr[cnt] <= dn_hold; // [RULE_15]
        // Reserved test bits are stored as written; the controller keeps them zero [RULE_02]
        if (cnt == SLMC_IDX_MASK && dn_hold[7:SLMC_SRC_LSB] != cr[SLMC_IDX_MASK][7:SLMC_SRC_LSB]) begin
          mask_chg <= 1'b1; // [RULE_12]
        end
      end
      if (state == ST_COEF && byte_rx) begin
        coef[cnt[2:0]] <= dn_hold; // [RULE_18]
      end
    end
  end

  // Settings registered so the analogue side sees clean levels
  always_ff @(posedge ref_clk) begin
    cfg.thr_volts <= slmc_thr(cr[SLMC_IDX_CFG][SLMC_THR_MSB:SLMC_THR_LSB]); // [RULE_01]
    cfg.rx_hp_bypass <= cr[SLMC_IDX_CFG][SLMC_HPD_BIT]; // [RULE_03]
    cfg.rx_pcm <= cr[SLMC_IDX_MASK][SLMC_RXC_BIT]; // [RULE_13]
    cfg.tx_pcm <= cr[SLMC_IDX_MASK][SLMC_TXC_BIT]; // [RULE_13]
    coef_bank <= coef;
  end

  property p_thr_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    (cr[SLMC_IDX_CFG][7:4] == 4'h0) |=> (cfg.thr_volts == 5'd0);
  endproperty
  a_thr_zero: assert property (p_thr_zero) else $error("zero threshold field not 0 V"); // [RULE_01]

  property p_thr_lin;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_WDATA && byte_rx && cnt == SLMC_IDX_CFG && dn_hold[7:4] != 4'h0) |-> ##2
      (cfg.thr_volts == 5'(5'd8 + {1'b0, $past(dn_hold[7:4], 2)}));
  endproperty
  a_thr_lin: assert property (p_thr_lin) else $error("threshold not 8 V plus count"); // [RULE_01]

  property p_hp_write;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_WDATA && byte_rx && cnt == SLMC_IDX_CFG) |-> ##2
      (cfg.rx_hp_bypass == |($past(dn_hold, 2) & 8'h02));
  endproperty
  a_hp_write: assert property (p_hp_write) else $error("high-pass bypass not following write"); // [RULE_03]

  property p_mask_reset;
    @(posedge ref_clk) $rose(rst_n) |-> ##1 (cfg.rx_pcm && cfg.tx_pcm && cr[SLMC_IDX_MASK] == 8'hFF);
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask not all ones after reset"); // [RULE_14]

  property p_echo;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_RESP && !busy && cnt == 4'd1 && !is_top) |=> (up_data[1:0] == echo_lsel && up_data[3:2] == 2'b01);
  endproperty
  a_echo: assert property (p_echo) else $error("echo byte lacks previous line select"); // [RULE_17]

  property p_sr_view;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_RESP && !busy && cnt == 4'd1 && is_top) |=>
      ((((up_data[7:2] ^ $past(shadow)) & ~$past(cr[SLMC_IDX_MASK][7:2])) == 6'h00) &&
       (((up_data[7:2] ^ $past(status[7:2])) & $past(cr[SLMC_IDX_MASK][7:2])) == 6'h00));
  endproperty
  a_sr_view: assert property (p_sr_view) else $error("unmasked status bits not from shadow"); // [RULE_08]

  property p_reply_addr;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_RESP && !busy && cnt == 4'd0) |=> (up_data == SLMC_ADDR_BYTE && busy);
  endproperty
  a_reply_addr: assert property (p_reply_addr) else $error("reply did not open with address"); // [RULE_16]

  property p_cop_store;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_COEF && byte_rx && cnt == 4'd7) |=> (coef[7] == $past(dn_hold) && state == ST_ADDR);
  endproperty
  a_cop_store: assert property (p_cop_store) else $error("last coefficient not stored"); // [RULE_18]

  property p_idle_rx;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == ST_RESP && byte_rx && !ack_seen) |=> (state == ST_RESP && $stable(cr));
  endproperty
  a_idle_rx: assert property (p_idle_rx) else $error("downstream byte acted on during reply"); // [RULE_19]

  c_top_read: cover property (@(posedge ref_clk) disable iff (!rst_n) readout);
  c_cop_done: cover property (@(posedge ref_clk) disable iff (!rst_n) state == ST_COEF ##1 state == ST_ADDR);
  c_sop12: cover property (@(posedge ref_clk) disable iff (!rst_n) state == ST_WDATA && len == SLMC_LEN_12 && cnt == 4'd11);

endmodule

/* src/slmc_pkg.sv */
// Purpose: Shared constants and types for the signalling mask and monitor command block
// Assumes: Monitor bytes arrive one per frame; control register index 0 is the first register
// Notes: Control register reset values are held here as one packed table
package slmc_pkg;

  // Monitor channel framing
  localparam logic [7:0] SLMC_ADDR_BYTE = 8'h81;
  localparam logic [7:0] SLMC_IDLE_BYTE = 8'hFF;
  localparam int SLMC_CMD_RD_BIT = 6;
  localparam int SLMC_LSEL_MSB = 5;
  localparam int SLMC_LSEL_LSB = 4;

  // Command low nibbles and the coefficient command
  localparam logic [3:0] SLMC_SOP_0 = 4'h4;
  localparam logic [3:0] SLMC_SOP_2 = 4'h5;
  localparam logic [3:0] SLMC_SOP_12 = 4'h6;
  localparam logic [3:0] SLMC_TOP_SR = 4'hC;
  localparam logic [6:0] SLMC_COP_WR = 7'h03;
  localparam logic [3:0] SLMC_ECHO_HI = 4'h0;
  localparam logic [1:0] SLMC_ECHO_MID = 2'b01;

  // Register file
  localparam int SLMC_NREG = 12;
  localparam int SLMC_NCOEF = 8;
  localparam logic [3:0] SLMC_LEN_2 = 4'd2;
  localparam logic [3:0] SLMC_LEN_12 = 4'd12;
  localparam logic [3:0] SLMC_IDX_CFG = 4'd10;
  localparam logic [3:0] SLMC_IDX_MASK = 4'd11;
  localparam logic [SLMC_NREG*8-1:0] SLMC_CR_RST = {8'hFF, 8'h10, 8'hFF, 8'h2F, 8'h00, 8'h1C,
                                                    8'h51, 8'h60, 8'hF9, 8'hA5, 8'h00, 8'h00};

  // Field positions
  localparam int SLMC_THR_MSB = 7;
  localparam int SLMC_THR_LSB = 4;
  localparam int SLMC_HPD_BIT = 1;
  localparam int SLMC_RXC_BIT = 1;
  localparam int SLMC_TXC_BIT = 0;
  localparam int SLMC_SRC_LSB = 2;
  localparam logic [4:0] SLMC_THR_BASE_V = 5'd8;

  // Frames the interrupt stays low after a readout that found a change
  localparam int SLMC_REARM_FRAMES = 2;

  typedef enum {ST_ADDR, ST_CMD, ST_WDATA, ST_COEF, ST_RESP} slmc_state_t;

  // Settings driven into the analogue and voice paths
  typedef struct packed {
    logic [4:0] thr_volts;
    logic rx_hp_bypass;
    logic rx_pcm;
    logic tx_pcm;
  } slmc_cfg_t;

  // Threshold in volts: zero field means 0 V, else base plus one volt per count
  function automatic logic [4:0] slmc_thr(input logic [3:0] field);
    slmc_thr = (field == 4'h0) ? 5'd0 : 5'(SLMC_THR_BASE_V + {1'b0, field});
  endfunction

endpackage

/* src/slmc_sync.sv */
// Purpose: Synchroniser for levels, toggles and pin inputs
// Assumes: Input changes slower than the destination clock
// Notes: With FILTER set a change counts only once the second and third stages agree
module slmc_sync #(
  parameter int W = 1,
  parameter bit FILTER = 1'b0
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] q_f;

  initial begin
    if (W < 1) $error("slmc_sync: width must be at least one");
  end

  // Stage one feeds stage two only
  always_ff @(posedge clk) begin
    s1 <= d;
    s2 <= s1;
    s3 <= s2;
  end

  // Filtered copy for pins, glitches shorter than a cycle never pass
  always_ff @(posedge clk) begin
    if (s2 == s3) begin
      q_f <= s3;
    end
  end

  assign q = FILTER ? q_f : s2;

endmodule

/* src/slmc_event.sv */
// Purpose: Signalling event detector with shadow register and interrupt bit
// Assumes: status is synchronised to clk; frame_tick pulses once per frame
// Notes: Mask bits that are one hide their source from the interrupt entirely
module slmc_event
  import slmc_pkg::*;
#(
  parameter int REARM_FRAMES = SLMC_REARM_FRAMES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] status,
  input wire logic [5:0] mask,
  input wire logic mask_chg,
  input wire logic readout,
  input wire logic frame_tick,
  output logic [5:0] shadow,
  output logic int_flag
);

  logic [5:0] prev;
  logic [1:0] rearm;
  logic toggled;
  logic differ;

  initial begin
    if (REARM_FRAMES < 1 || REARM_FRAMES > 3) $error("slmc_event: REARM_FRAMES must be 1 to 3");
  end

  // Only unmasked sources count as events or as differences
  assign toggled = |((status ^ prev) & ~mask); // [RULE_04]
  assign differ = |((shadow ^ status) & ~mask);

  // Shadow and interrupt; a mask change outranks a readout, which outranks new events
  always_ff @(posedge clk) begin
    prev <= status;
    if (!rst_n) begin
      shadow <= status; // [RULE_11]
      int_flag <= 1'b0;
      rearm <= 2'd0;
    end else if (mask_chg) begin
      shadow <= status; // [RULE_12]
      int_flag <= 1'b0;
      rearm <= 2'd0;
    end else if (readout) begin
      int_flag <= 1'b0; // [RULE_10]
      if (differ) begin
        shadow <= status; // [RULE_09]
        rearm <= 2'(REARM_FRAMES);
      end else begin
        rearm <= 2'd0; // [RULE_10]
      end
    end else if (rearm != 2'd0) begin
      if (frame_tick) begin
        rearm <= 2'(rearm - 2'd1);
        if (rearm == 2'd1) begin
          int_flag <= 1'b1; // [RULE_09]
        end
      end
    end else if (!int_flag && toggled) begin
      shadow <= status; // [RULE_05] [RULE_06]
      int_flag <= 1'b1;
    end
    // Once set, further events are ignored until readout or a mask change [RULE_07]
  end

  property p_masked_quiet;
    @(posedge clk) disable iff (!rst_n)
    (!int_flag && rearm == 2'd0 && !toggled) |=> !int_flag;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("interrupt rose with no unmasked toggle"); // [RULE_05]

  property p_event_sets;
    @(posedge clk) disable iff (!rst_n)
    (!int_flag && rearm == 2'd0 && toggled && !mask_chg && !readout) |=> (int_flag && shadow == $past(status));
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event did not capture and interrupt"); // [RULE_06]

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    (int_flag && !readout && !mask_chg) |=> (int_flag && $stable(shadow));
  endproperty
  a_hold: assert property (p_hold) else $error("latched interrupt or shadow moved"); // [RULE_07]

  property p_rearm_start;
    @(posedge clk) disable iff (!rst_n)
    (readout && differ && !mask_chg) |=> (!int_flag && rearm == 2'(REARM_FRAMES) && shadow == $past(status));
  endproperty
  a_rearm_start: assert property (p_rearm_start) else $error("readout with change did not recapture"); // [RULE_09]

  property p_rearm_end;
    @(posedge clk) disable iff (!rst_n)
    (rearm == 2'd1 && frame_tick && !readout && !mask_chg) |=> int_flag;
  endproperty
  a_rearm_end: assert property (p_rearm_end) else $error("interrupt not raised after low frames"); // [RULE_09]

  property p_clean_readout;
    @(posedge clk) disable iff (!rst_n)
    (readout && !differ && !mask_chg) |=> (!int_flag && rearm == 2'd0);
  endproperty
  a_clean_readout: assert property (p_clean_readout) else $error("interrupt rearmed with no change"); // [RULE_10]

  property p_mask_chg;
    @(posedge clk) disable iff (!rst_n)
    mask_chg |=> (!int_flag && shadow == $past(status));
  endproperty
  a_mask_chg: assert property (p_mask_chg) else $error("mask change did not recapture and clear"); // [RULE_12]

  property p_reset_load;
    @(posedge clk) $rose(rst_n) |-> (shadow == $past(status) && !int_flag);
  endproperty
  a_reset_load: assert property (p_reset_load) else $error("shadow not loaded from status at reset"); // [RULE_11]

  c_rearm: cover property (@(posedge clk) disable iff (!rst_n) readout && differ);
  c_event: cover property (@(posedge clk) disable iff (!rst_n) !int_flag ##1 int_flag);

endmodule

/* tb/slmc_gci_ctrl.sv */
// Purpose: Line card controller model on the monitor channel
// Assumes: FRAME link clocks per frame, one downstream byte per frame
// Notes: Drives on falling link edges; keeps every upstream byte in order
module slmc_gci_ctrl #(
  parameter int FRAME = 64
) (
  input wire logic gci_clk,
  output logic frame_sync,
  output logic mon_dn_valid,
  output logic [7:0] mon_dn_data,
  input wire logic mon_up_valid,
  input wire logic [7:0] mon_up_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int fcnt = 0;
  logic [7:0] rx_q[$];
  // Frame counter; the sync pulse lasts one link clock
  always @(negedge gci_clk) begin
    fcnt <= (fcnt == FRAME - 1) ? 0 : fcnt + 1;
  end
  assign frame_sync = (fcnt == 0);
  // Idle pattern whenever no byte is offered
  initial begin
    mon_dn_valid = 1'b0;
    mon_dn_data = 8'hFF;
  end
  // One byte per frame, clear of the sync edge so the device never sees two
  task automatic send(input logic [7:0] b);
    @(negedge gci_clk iff fcnt == 3);
    mon_dn_valid = 1'b1;
    mon_dn_data = b;
    @(negedge gci_clk);
    mon_dn_valid = 1'b0;
    mon_dn_data = 8'hFF;
  endtask
  // Upstream bytes collected for the bench to compare
  always @(posedge gci_clk) begin
    if (mon_up_valid) rx_q.push_back(mon_up_data);
  end
endmodule

/* tb/slmc_top_tb.sv */
// Purpose: Self-checking bench for the monitor command block
// Assumes: Link clock 12 ns free running; register clock 50 ns
// Notes: Register, coefficient and status values drawn from a fixed seed
module slmc_top_tb
  import slmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FRAME = 64;
  logic ref_clk = 0, gci_clk = 0, rst_n = 0;
  logic frame_sync, mon_dn_valid, mon_up_valid, ci_up_int;
  logic [7:0] mon_dn_data, mon_up_data, status_in, sh;
  slmc_cfg_t cfg;
  logic [SLMC_NCOEF*8-1:0] coef_bank, cb;
  logic [7:0] regs [SLMC_NREG];
  logic [1:0] lsel = 2'b00;
  int n_mismatch = 0, checks = 0, seed = 32'h5092;
  // Clocks unrelated in phase
  initial forever #25 ref_clk = ~ref_clk;
  initial forever #6 gci_clk = ~gci_clk;
  slmc_top i_dut (.ref_clk, .rst_n, .gci_clk, .frame_sync, .mon_dn_valid, .mon_dn_data, .mon_up_valid,
    .mon_up_data, .ci_up_int, .status_in, .cfg, .coef_bank);
  slmc_gci_ctrl #(.FRAME(FRAME)) i_ctl (.gci_clk, .frame_sync, .mon_dn_valid, .mon_dn_data, .mon_up_valid,
    .mon_up_data);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Threshold zero means 0 V, else 8 V plus the field
  function automatic logic [7:0] exp_cfg(input logic [7:0] c11, input logic [7:0] c12);
    exp_cfg = {(c11[7:4] == 4'h0) ? 5'h00 : 5'h08 + {1'b0, c11[7:4]}, c11[1], c12[1], c12[0]};
  endfunction
  // Waits boundedly for the next reply byte
  task automatic rx(input logic [7:0] exp, input string what);
    int n = 0;
    while (i_ctl.rx_q.size() == 0 && n < 8 * FRAME) begin
      @(posedge gci_clk);
      n++;
    end
    chk((i_ctl.rx_q.size() > 0) ? i_ctl.rx_q.pop_front() : 8'hxx, exp, what);
  endtask
  task automatic wait_int(input logic v, input int lim, input string what);
    int n = 0;
    while (ci_up_int !== v && n < lim) begin
      @(posedge gci_clk);
      n++;
    end
    chk({7'h00, ci_up_int}, {7'h00, v}, what);
  endtask
  task automatic wr(input logic [1:0] ls, input logic [3:0] nib, input int n);
    i_ctl.send(8'h81);
    i_ctl.send({2'b00, ls, nib});
    lsel = ls;
    for (int k = 0; k < n; k++) i_ctl.send(regs[k]);
  endtask
  // Trailing frame lets the last reply byte expire before the next command
  task automatic rd(input logic [1:0] ls, input logic [3:0] nib, input int n);
    i_ctl.send(8'h81);
    i_ctl.send({2'b01, ls, nib});
    rx(8'h81, "read addr");
    rx({4'h0, 2'b01, lsel}, "echo");
    lsel = ls;
    for (int k = 0; k < n; k++) rx(regs[k], "reg");
    repeat (FRAME) @(posedge gci_clk);
  endtask
  task automatic rd_sr(input logic [7:0] exp);
    i_ctl.send(8'h81);
    i_ctl.send({4'h4, SLMC_TOP_SR});
    rx(8'h81, "status addr");
    rx(exp, "status");
  endtask
  task automatic flip(input int b);
    @(negedge ref_clk);
    status_in[b] = ~status_in[b];
  endtask
  // Upstream must idle while a byte goes downstream
  always @(posedge gci_clk) begin
    if (rst_n && mon_dn_valid) chk(mon_up_data, 8'hFF, "up idle");
  end
  task automatic close_out;
    $display("Checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    n_mismatch++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    close_out();
  end
  initial begin
    int n;
    status_in = 8'($random(seed));
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (8) @(posedge gci_clk);
    chk(cfg, exp_cfg(8'h10, 8'hFF), "reset cfg");
    for (int k = 0; k < SLMC_NREG; k++) regs[k] = SLMC_CR_RST[8*k+:8];
    rd(2'b00, SLMC_SOP_12, 12);
    // Every write and read length, threshold at zero and at its top
    for (int i = 0; i < 4; i++) begin
      n = (i == 0) ? 0 : (i == 1) ? 2 : 12;
      for (int k = 0; k < n; k++) regs[k] = 8'($random(seed));
      if (i >= 2) regs[10][7:2] = {(i == 2) ? 4'h0 : 4'hF, 2'b00};
      wr(2'($random(seed)), (i == 0) ? SLMC_SOP_0 : (i == 1) ? SLMC_SOP_2 : SLMC_SOP_12, n);
      rd(2'($random(seed)), (i == 0) ? SLMC_SOP_0 : (i == 1) ? SLMC_SOP_2 : SLMC_SOP_12, n);
      chk(cfg, exp_cfg(regs[10], regs[11]), "cfg");
    end
    i_ctl.send(8'h81);
    i_ctl.send({1'($random(seed)), SLMC_COP_WR});
    for (int k = 0; k < SLMC_NCOEF; k++) begin
      cb[8*k+:8] = 8'($random(seed));
      i_ctl.send(cb[8*k+:8]);
    end
    repeat (FRAME) @(posedge gci_clk);
    for (int k = 0; k < SLMC_NCOEF; k++) chk(coef_bank[8*k+:8], cb[8*k+:8], "coef");
    // Only the hook source unmasked
    regs[11] = 8'h7F;
    wr(2'b00, SLMC_SOP_12, 12);
    wait_int(1'b0, 4 * FRAME, "mask write");
    flip(6);
    repeat (4 * FRAME) @(posedge gci_clk);
    wait_int(1'b0, 0, "masked toggle");
    flip(7);
    sh = status_in;
    wait_int(1'b1, 4 * FRAME, "event");
    flip(7);
    flip(5);
    repeat (FRAME) @(posedge gci_clk);
    wait_int(1'b1, 0, "held");
    rd_sr({sh[7], status_in[6:0]});
    wait_int(1'b0, 3 * FRAME, "cleared");
    repeat (FRAME) @(posedge gci_clk);
    wait_int(1'b0, 0, "low window");
    wait_int(1'b1, 3 * FRAME, "rearm");
    rd_sr(status_in);
    wait_int(1'b0, 3 * FRAME, "cleared again");
    repeat (4 * FRAME) @(posedge gci_clk);
    wait_int(1'b0, 0, "stays clear");
    flip(7);
    wait_int(1'b1, 4 * FRAME, "new event");
    regs[11] = 8'hFF;
    wr(2'b00, SLMC_SOP_12, 12);
    wait_int(1'b0, 4 * FRAME, "mask change clears");
    close_out();
  end
endmodule
